// File: shared/sgc_pkg.sv
// Package for the switch global control bank, registers 5 to 9.
// Assumes one 200 MHz clock and a plain byte-wide register port.
`default_nettype none
package sgc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_VLAN_IGMP_PRIO = 8'h05;
  localparam logic [7:0] OFS_MII_VID_STORM  = 8'h06;
  localparam logic [7:0] OFS_STORM_LOW      = 8'h07;
  localparam logic [7:0] OFS_FACTORY_A      = 8'h08;
  localparam logic [7:0] OFS_FACTORY_B      = 8'h09;
  localparam logic [7:0] OFS_MCAST_CTRL     = 8'h04;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_VLAN_EN    = 7;
  localparam int BIT_IGMP_SNOOP = 6;
  localparam int BIT_PRIO_HI    = 3;
  localparam int BIT_PRIO_LO    = 2;
  localparam int BIT_SNIFF_AND  = 0;
  localparam int BIT_HALF_DPX   = 6;
  localparam int BIT_FLOW_CTRL  = 5;
  localparam int BIT_TEN_MEG    = 4;
  localparam int BIT_NULL_VID   = 3;
  localparam int BIT_STORM_HI   = 2;
  localparam int BIT_MCAST_DIS  = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_VLAN_IGMP_PRIO = 8'h00;
  localparam logic [7:0] RST_MII_VID_STORM  = 8'h00;
  localparam logic [7:0] RST_STORM_LOW      = 8'h63;
  localparam logic [7:0] RST_FACTORY_A      = 8'h4e;
  localparam logic [7:0] RST_FACTORY_B      = 8'h24;
  localparam logic [7:0] RST_MCAST_CTRL     = 8'h40;

  // ---------------------------------------------------------------
  // Storm interval timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int STORM_MS_100M    = 67;
  localparam int STORM_MS_10M     = 500;
  localparam int STORM_CYC_100M   = STORM_MS_100M * CLK_MHZ * 1000;
  localparam int STORM_CYC_10M    = STORM_MS_10M * CLK_MHZ * 1000;

  // Scheduling ratio counts, high packets per low packet
  localparam logic [3:0] RATIO_10 = 4'ha;
  localparam logic [3:0] RATIO_5  = 4'h5;
  localparam logic [3:0] RATIO_2  = 4'h2;

  typedef enum logic [1:0]
  {
    SGC_PRIO_STRICT = 2'b00,
    SGC_PRIO_10_1   = 2'b01,
    SGC_PRIO_5_1    = 2'b10,
    SGC_PRIO_2_1    = 2'b11
  } sgc_prio_t;
endpackage : sgc_pkg
`default_nettype wire

// File: shared/sgc_cfg_if.sv
// Configuration bundle from the register bank to the storm meter.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`default_nettype none
interface sgc_cfg_if;
  logic        ten_megabit_select;
  logic [10:0] storm_rate;
  logic        interval_tick;
  modport bank  (output ten_megabit_select, output storm_rate,
                 input interval_tick);
  modport meter (input ten_megabit_select, input storm_rate,
                 output interval_tick);
endinterface : sgc_cfg_if
`default_nettype wire

// File: design/sgc_storm_meter.sv
// Storm protection meter: interval timer and 64-byte block budget.
// Assumes the caller gives one pulse per 64-byte block of storm traffic.
`timescale 1ns/1ps
`default_nettype none
module sgc_storm_meter #(
  parameter int CYC_100M = sgc_pkg::STORM_CYC_100M,
  parameter int CYC_10M  = sgc_pkg::STORM_CYC_10M
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  sgc_cfg_if.meter  cfg,
  input  wire logic block_in,
  output logic      storm_drop
);
  logic [31:0] tmr_ff;
  logic [10:0] used_ff;
  logic [31:0] limit;
  logic        at_end;
  logic        over;

  // Interval length follows the port speed
  assign limit  = cfg.ten_megabit_select ? 32'(CYC_10M - 1)
                                         : 32'(CYC_100M - 1);
  assign at_end = (tmr_ff >= limit);
  assign over   = (used_ff >= cfg.storm_rate);
  assign cfg.interval_tick = ce & at_end;
  assign storm_drop = block_in & over;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tmr_ff  <= 32'h0;
      used_ff <= 11'h0;
    end
    else if (ce)
    begin
      tmr_ff  <= at_end ? 32'h0 : tmr_ff + 32'h1;
      if (at_end)
        used_ff <= 11'h0;
      else if (block_in && !over)
        used_ff <= used_ff + 11'h1;
    end
  end
endmodule : sgc_storm_meter
`default_nettype wire

// File: design/sgc_global_ctrl.sv
// Global control bank, registers 5 to 9, plus the multicast storm bit.
// Assumes a byte register port with one-cycle strobes and strap pins
// that are static around reset.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - VLAN enable bit turns 802.1Q mode on
// - IGMP snoop sends IGMP to MII port
// - Two-bit field picks strict or ratio scheduling
// - Sniff select one: source and destination match
// - Sniff select zero: source or destination match
// - Duplex bit set means half duplex
// - Flow control bit enables pause on MII
// - Speed bit set means 10 Mbps
// - Duplex, flow, speed load from straps
// - Null VID replaced by port default VID
// - Eleven-bit storm rate in 64-byte blocks
// - Interval 500 ms at 10M, 67 ms 100M
// - Storm rate resets to 0x063
// - Broadcast always metered, multicast when enabled
module sgc_global_ctrl #(
  parameter int CYC_100M = sgc_pkg::STORM_CYC_100M,
  parameter int CYC_10M  = sgc_pkg::STORM_CYC_10M
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        duplex_strap_pin,
  input  wire logic        flow_control_strap_pin,
  input  wire logic        speed_strap_pin,
  input  wire logic [11:0] port_default_vid,
  input  wire logic [11:0] rx_vid,
  output logic      [11:0] rx_vid_out,
  input  wire logic        pkt_is_igmp,
  output logic             igmp_to_mii,
  input  wire logic        src_sniff_match,
  input  wire logic        dst_sniff_match,
  output logic             sniff_mirror,
  input  wire logic        hi_pending,
  input  wire logic        lo_pending,
  input  wire logic        pkt_sent,
  output logic             sched_pick_hi,
  input  wire logic        storm_block,
  input  wire logic        da_all_ones,
  input  wire logic        da_group_bit,
  output logic             storm_drop,
  output logic             storm_interval_tick,
  output logic             vlan_mode,
  output logic             mii_half_duplex,
  output logic             mii_flow_ctrl,
  output logic             mii_ten_meg
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] ctl3_ff;
  logic [7:0] ctl4_ff;
  logic [7:0] ctl5_ff;
  logic [7:0] fta_ff;
  logic [7:0] ftb_ff;
  logic [7:0] mcast_ff;
  logic [7:0] rdata_ff;
  logic [2:0] dup_sync_ff;
  logic [2:0] flow_sync_ff;
  logic [2:0] spd_sync_ff;
  logic [1:0] strap_wait_ff;
  logic       strap_done_ff;
  logic [3:0] hi_cnt_ff;
  logic [3:0] nxt_hi_cnt;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire hit3 = (reg_addr == sgc_pkg::OFS_VLAN_IGMP_PRIO);
  wire hit4 = (reg_addr == sgc_pkg::OFS_MII_VID_STORM);
  wire hit5 = (reg_addr == sgc_pkg::OFS_STORM_LOW);
  wire hit6 = (reg_addr == sgc_pkg::OFS_FACTORY_A);
  wire hit7 = (reg_addr == sgc_pkg::OFS_FACTORY_B);
  wire hitm = (reg_addr == sgc_pkg::OFS_MCAST_CTRL);
  logic [7:0] rd_mux;

  always_comb
  begin
    if (hit3)
      rd_mux = ctl3_ff;
    else if (hit4)
      rd_mux = ctl4_ff;
    else if (hit5)
      rd_mux = ctl5_ff;
    else if (hit6)
      rd_mux = fta_ff;
    else if (hit7)
      rd_mux = ftb_ff;
    else if (hitm)
      rd_mux = mcast_ff;
    else
      rd_mux = 8'h00;
  end

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  // Straps pass three flops; loaded once the last two agree after reset
  wire dup_ok  = (dup_sync_ff[2] == dup_sync_ff[1]);
  wire flow_ok = (flow_sync_ff[2] == flow_sync_ff[1]);
  wire spd_ok  = (spd_sync_ff[2] == spd_sync_ff[1]);
  wire strap_load = ce & ~strap_done_ff & (strap_wait_ff == 2'h3)
                    & dup_ok & flow_ok & spd_ok;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dup_sync_ff   <= 3'h0;
      flow_sync_ff  <= 3'h0;
      spd_sync_ff   <= 3'h0;
      strap_wait_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end
    else if (ce)
    begin
      dup_sync_ff  <= {dup_sync_ff[1:0], duplex_strap_pin};
      flow_sync_ff <= {flow_sync_ff[1:0], flow_control_strap_pin};
      spd_sync_ff  <= {spd_sync_ff[1:0], speed_strap_pin};
      if (strap_wait_ff != 2'h3)
        strap_wait_ff <= strap_wait_ff + 2'h1;
      if (strap_load)
        strap_done_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Strap load wins over a same-cycle write on the duplex, flow and speed bits only; software retries
  logic [7:0] nxt_ctl4;
  always_comb
  begin
    nxt_ctl4 = ctl4_ff;
    if (reg_wr && hit4)
      nxt_ctl4 = reg_wdata;
    if (strap_load)
    begin
      nxt_ctl4[sgc_pkg::BIT_HALF_DPX]  = dup_sync_ff[2];
      nxt_ctl4[sgc_pkg::BIT_FLOW_CTRL] = flow_sync_ff[2];
      nxt_ctl4[sgc_pkg::BIT_TEN_MEG]   = spd_sync_ff[2];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctl3_ff  <= sgc_pkg::RST_VLAN_IGMP_PRIO;
      ctl4_ff  <= sgc_pkg::RST_MII_VID_STORM;
      ctl5_ff  <= sgc_pkg::RST_STORM_LOW;
      fta_ff   <= sgc_pkg::RST_FACTORY_A;
      ftb_ff   <= sgc_pkg::RST_FACTORY_B;
      mcast_ff <= sgc_pkg::RST_MCAST_CTRL;
    end
    else if (ce)
    begin
      if (reg_wr && hit3)
        ctl3_ff <= reg_wdata;
      ctl4_ff <= nxt_ctl4;
      if (reg_wr && hit5)
        ctl5_ff <= reg_wdata;
      if (reg_wr && hit6)
        fta_ff <= reg_wdata;
      if (reg_wr && hit7)
        ftb_ff <= reg_wdata;
      if (reg_wr && hitm)
        mcast_ff <= reg_wdata;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata_ff <= 8'h00;
    else if (ce)
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
  end
  assign reg_rdata = rdata_ff;

  // ---------------------------------------------------------------
  // Control decode
  // ---------------------------------------------------------------
  assign vlan_mode   = ctl3_ff[sgc_pkg::BIT_VLAN_EN];
  assign igmp_to_mii = pkt_is_igmp
                       & ctl3_ff[sgc_pkg::BIT_IGMP_SNOOP];
  assign sniff_mirror = ctl3_ff[sgc_pkg::BIT_SNIFF_AND]
                        ? (src_sniff_match & dst_sniff_match)
                        : (src_sniff_match | dst_sniff_match);
  assign mii_half_duplex = ctl4_ff[sgc_pkg::BIT_HALF_DPX];
  assign mii_flow_ctrl   = ctl4_ff[sgc_pkg::BIT_FLOW_CTRL];
  assign mii_ten_meg     = ctl4_ff[sgc_pkg::BIT_TEN_MEG];
  assign rx_vid_out = (ctl4_ff[sgc_pkg::BIT_NULL_VID] && rx_vid == 12'h000)
                      ? port_default_vid : rx_vid;

  // ---------------------------------------------------------------
  // Priority scheduler
  // ---------------------------------------------------------------
  sgc_pkg::sgc_prio_t prio_mode;
  logic [3:0]         ratio;
  assign prio_mode = sgc_pkg::sgc_prio_t'(
    ctl3_ff[sgc_pkg::BIT_PRIO_HI:sgc_pkg::BIT_PRIO_LO]);

  always_comb
  begin
    case (prio_mode)
      sgc_pkg::SGC_PRIO_10_1: ratio = sgc_pkg::RATIO_10;
      sgc_pkg::SGC_PRIO_5_1:  ratio = sgc_pkg::RATIO_5;
      sgc_pkg::SGC_PRIO_2_1:  ratio = sgc_pkg::RATIO_2;
      default:                ratio = 4'h0;
    endcase
  end

  // Low gets a turn after ratio high sends, or when high is idle
  wire strict   = (prio_mode == sgc_pkg::SGC_PRIO_STRICT);
  wire lo_turn  = ~strict & lo_pending & (hi_cnt_ff >= ratio);
  assign sched_pick_hi = hi_pending & ~lo_turn;

  always_comb
  begin
    nxt_hi_cnt = hi_cnt_ff;
    if (pkt_sent)
      nxt_hi_cnt = sched_pick_hi ? hi_cnt_ff + 4'h1 : 4'h0;
    if (strict || nxt_hi_cnt > sgc_pkg::RATIO_10)
      nxt_hi_cnt = sgc_pkg::RATIO_10;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      hi_cnt_ff <= 4'h0;
    else if (ce)
      hi_cnt_ff <= nxt_hi_cnt;
  end

  // ---------------------------------------------------------------
  // Storm protection
  // ---------------------------------------------------------------
  sgc_cfg_if cfg ();
  logic storm_class;
  logic meter_drop;

  assign cfg.ten_megabit_select = mii_ten_meg;
  assign cfg.storm_rate = {ctl4_ff[sgc_pkg::BIT_STORM_HI:0], ctl5_ff};
  assign storm_class = da_all_ones
                       | (da_group_bit
                          & ~mcast_ff[sgc_pkg::BIT_MCAST_DIS]);

  sgc_storm_meter #(
    .CYC_100M (CYC_100M),
    .CYC_10M  (CYC_10M)
  ) u_meter (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .cfg        (cfg),
    .block_in   (storm_block & storm_class),
    .storm_drop (meter_drop)
  );
  assign storm_drop          = meter_drop;
  assign storm_interval_tick = cfg.interval_tick;
endmodule : sgc_global_ctrl
`default_nettype wire

// File: verification/sgc_global_ctrl_props.sv
// Port checker for the global control bank.
// Assumes a bind onto every sgc_global_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module sgc_global_ctrl_props #(
  parameter int CYC_100M = 20,
  parameter int CYC_10M  = 50
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [11:0] rx_vid,
  input wire logic [11:0] rx_vid_out,
  input wire logic        pkt_is_igmp,
  input wire logic        igmp_to_mii,
  input wire logic        src_sniff_match,
  input wire logic        dst_sniff_match,
  input wire logic        sniff_mirror,
  input wire logic        storm_interval_tick,
  input wire logic        vlan_mode,
  input wire logic        mii_half_duplex,
  input wire logic        mii_flow_ctrl,
  input wire logic        mii_ten_meg
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ----
  // Interval gap, trusted only while speed holds
  // ----
  int   gap_ff;
  logic ok_ff;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      gap_ff <= 0;
      ok_ff  <= 1'b0;
    end
    else if (ce)
    begin
      gap_ff <= storm_interval_tick ? 1 : gap_ff + 1;
      ok_ff  <= !$changed(mii_ten_meg) && (ok_ff || storm_interval_tick);
    end
  end
  sequence s_wr_low;
    ce && reg_wr && reg_addr == sgc_pkg::OFS_STORM_LOW;
  endsequence
  sequence s_rd_low;
    ce && reg_rd && reg_addr == sgc_pkg::OFS_STORM_LOW;
  endsequence
  AST_VLAN_WR: assert property (
    ce && reg_wr && reg_addr == sgc_pkg::OFS_VLAN_IGMP_PRIO
    |=> {vlan_mode, 7'h00} == ($past(reg_wdata) & 8'h80))
    else $error("vlan mode missed a write");
  AST_MII_WR: assert property (
    ce && reg_wr && reg_addr == sgc_pkg::OFS_MII_VID_STORM
    |=> {1'b0, mii_half_duplex, mii_flow_ctrl, mii_ten_meg, 4'h0}
        == ($past(reg_wdata) & 8'h70))
    else $error("port mode missed a write");
  AST_IGMP_GATE: assert property (
    !pkt_is_igmp |-> !igmp_to_mii)
    else $error("igmp forward without igmp");
  AST_SNIFF_BOTH: assert property (
    src_sniff_match && dst_sniff_match |-> sniff_mirror)
    else $error("mirror missed full match");
  AST_SNIFF_NONE: assert property (
    !src_sniff_match && !dst_sniff_match |-> !sniff_mirror)
    else $error("mirror without match");
  AST_VID_KEEP: assert property (
    rx_vid != 12'h000 |-> rx_vid_out == rx_vid)
    else $error("vid altered");
  AST_LOW_RDBACK: assert property (
    s_wr_low ##1 s_rd_low |=> reg_rdata == $past(reg_wdata, 2))
    else $error("rate low byte read back wrong");
  AST_INTERVAL: assert property (
    ce && storm_interval_tick && ok_ff && $stable(mii_ten_meg)
    |-> gap_ff == (mii_ten_meg ? CYC_10M : CYC_100M))
    else $error("interval length wrong");
endmodule : sgc_global_ctrl_props
bind sgc_global_ctrl sgc_global_ctrl_props #(
  .CYC_100M(CYC_100M), .CYC_10M(CYC_10M)
) u_props (.*);
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the global control bank.
// Assumes short storm intervals and straps pulled high except in t_straps.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        strap = 1'b1, igmp = 1'b0, src = 1'b0, dst = 1'b0;
  logic        hi = 1'b0, lo = 1'b0, sent = 1'b0;
  logic        blk = 1'b0, all1 = 1'b0, grp = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00;
  logic [11:0] vid = 12'h000;
  wire  [7:0]  rdata;
  wire  [11:0] vid_out;
  wire         igmp_o, mir, pick, drop, tick, vlan, hd, fc, tm;
  int          fails = 0, n_tests = 0;
  always #2.5 mclk = ~mclk;
  sgc_global_ctrl #(.CYC_100M(20), .CYC_10M(50)) DUT (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .duplex_strap_pin(strap), .flow_control_strap_pin(strap),
    .speed_strap_pin(strap), .port_default_vid(12'h5a3),
    .rx_vid(vid), .rx_vid_out(vid_out), .pkt_is_igmp(igmp),
    .igmp_to_mii(igmp_o), .src_sniff_match(src), .dst_sniff_match(dst),
    .sniff_mirror(mir), .hi_pending(hi), .lo_pending(lo),
    .pkt_sent(sent), .sched_pick_hi(pick), .storm_block(blk),
    .da_all_ones(all1), .da_group_bit(grp), .storm_drop(drop),
    .storm_interval_tick(tick), .vlan_mode(vlan),
    .mii_half_duplex(hd), .mii_flow_ctrl(fc), .mii_ten_meg(tm)
  );
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Strobes stay up until the next task or idle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge mclk) #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge mclk) #1;
    chk(12'(rdata), 12'(e));
  endtask : rd_chk
  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk) #1;
  endtask : idle
  task automatic wait_tick();
    for (int i = 0; i < 200 && tick !== 1'b1; i++)
      @(negedge mclk);
    if (tick !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
    @(posedge mclk) #1;
  endtask : wait_tick
  task automatic burst(input logic cnt);
    blk <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      @(negedge mclk);
      chk(12'(drop), 12'(cnt && k >= 3));
      @(posedge mclk) #1;
    end
    blk <= 1'b0;
  endtask : burst
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    logic [7:0] e [8] = '{8'h00, 8'h40, 8'h00, 8'h70,
                          8'h63, 8'h4e, 8'h24, 8'h00};
    for (int i = 0; i < 8; i++)
      rd_chk(8'h03 + 8'(i), e[i]);
    idle();
    chk(12'({hd, fc, tm}), 12'h007);
    $display("t_reset end");
  endtask : t_reset
  task automatic t_rw();
    for (int i = 5; i < 11; i++)
    begin
      wr_reg(8'(i), 8'ha5);
      rd_chk(8'(i), i < 10 ? 8'ha5 : 8'h00);
    end
    ce <= 1'b0;
    wr_reg(8'h07, 8'h5a);
    ce <= 1'b1;
    rd_chk(8'h07, 8'ha5);
    idle();
    $display("t_rw end");
  endtask : t_rw
  task automatic t_fields();
    wr_reg(8'h05, 8'hc1);
    idle();
    igmp <= 1'b1;
    src <= 1'b1;
    @(posedge mclk) #1;
    chk(12'({vlan, igmp_o, mir}), 12'h006);
    dst <= 1'b1;
    @(posedge mclk) #1;
    chk(12'(mir), 12'h001);
    dst <= 1'b0;
    wr_reg(8'h05, 8'h00);
    idle();
    chk(12'({vlan, igmp_o, mir}), 12'h001);
    $display("t_fields end");
  endtask : t_fields
  task automatic t_mii();
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(8'h06, {1'b0, 3'(i), 4'h8});
      idle();
      chk(12'({hd, fc, tm}), 12'(i));
      chk(vid_out, 12'h5a3);
    end
    vid <= 12'h123;
    wr_reg(8'h06, 8'h00);
    idle();
    chk(vid_out, 12'h123);
    vid <= 12'h000;
    @(posedge mclk) #1;
    chk(vid_out, 12'h000);
    $display("t_mii end");
  endtask : t_mii
  task automatic t_sched();
    logic [3:0]  n [4] = '{4'h0, 4'ha, 4'h5, 4'h2};
    logic [11:0] run;
    logic        seen;
    hi <= 1'b1;
    lo <= 1'b1;
    sent <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(8'h05, {4'h0, 2'(m), 2'b00});
      idle();
      seen = 1'b0;
      run = 12'h000;
      for (int k = 0; k < 40; k++)
      begin
        @(negedge mclk);
        if (pick === 1'b1)
          run++;
        else if (!seen)
        begin
          seen = 1'b1;
          run = 12'h000;
        end
        else
          break;
      end
      @(posedge mclk) #1;
      chk(m == 0 ? 12'(seen) : run, 12'(n[m]));
    end
    sent <= 1'b0;
    $display("t_sched end");
  endtask : t_sched
  task automatic t_storm();
    wr_reg(8'h06, 8'h01);
    wr_reg(8'h07, 8'h00);
    idle();
    all1 <= 1'b1;
    wait_tick();
    burst(1'b0);
    wr_reg(8'h06, 8'h00);
    wr_reg(8'h07, 8'h03);
    idle();
    wait_tick();
    burst(1'b1);
    all1 <= 1'b0;
    grp <= 1'b1;
    wait_tick();
    burst(1'b0);
    wr_reg(8'h04, 8'h00);
    idle();
    wait_tick();
    burst(1'b1);
    wr_reg(8'h06, 8'h10);
    idle();
    repeat (3) wait_tick();
    chk(12'(tm), 12'h001);
    $display("t_storm end");
  endtask : t_storm
  // Mid-run reset with straps low: pull-down defaults must load
  task automatic t_straps();
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'h63);
    idle();
    chk(12'({hd, fc, tm}), 12'h000);
    $display("t_straps end");
  endtask : t_straps
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    t_reset();
    t_rw();
    t_fields();
    t_mii();
    t_sched();
    t_storm();
    t_straps();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
